// ### design/pfc_cfg.svh
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// Software register offsets (byte addresses)
`define PFC_OFF_CTRL 8'h00
`define PFC_OFF_ADDR 8'h04
`define PFC_OFF_WDATA 8'h08
`define PFC_OFF_CMD 8'h0C
`define PFC_OFF_STATUS 8'h10
`define PFC_OFF_RDATA 8'h14
`define PFC_OFF_TIMING 8'h18

// Control register fields
`define PFC_CTRL_RESET_BIT 0
`define PFC_CTRL_WORD_BIT 1
`define PFC_CTRL_PEN_BIT 2
`define PFC_CTRL_RESET_VAL 3'h0

// Command register codes
`define PFC_CMD_READ 2'h1
`define PFC_CMD_WRITE 2'h2

// Status register fields
`define PFC_ST_BUSY_BIT 0
`define PFC_ST_DONE_BIT 1
`define PFC_ST_READY_BIT 2
`define PFC_ST_PULSE_BIT 3
`define PFC_ST_REFUSED_BIT 4

// Timing in ns at 20 ns clock
`define PFC_CLK_NS 20
`define PFC_T_STROBE_NS 100
`define PFC_T_SETUP_NS 40
`define PFC_T_HOLD_NS 40
`define PFC_T_WAKE_NS 220
`define PFC_CYC_STROBE ((`PFC_T_STROBE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_SETUP ((`PFC_T_SETUP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_HOLD ((`PFC_T_HOLD_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_WAKE ((`PFC_T_WAKE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)

`endif

// ### design/pfc_ctrl.sv
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_ctrl
  import pfc_pkg::*;
#(
  parameter int ADDR_MSB = 23,
  parameter logic [2:0] CE_ACTIVE = 3'h0,
  parameter logic [2:0] CE_IDLE = 3'h7
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Software register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash address and strobes
  output logic [ADDR_MSB:1] flash_addr,
  output logic byte_lane_select,
  output logic [2:0] flash_ce,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_byte_n,
  output logic reset_powerdown_n,
  output logic program_enable_level,
  // Flash data bus
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic [1:0] flash_dq_oe,
  // Indicator, open drain with pull-up
  input wire logic state_machine_indicator
);
  logic [2:0] ctrl_r;
  logic [ADDR_MSB:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic [7:0] setup_r;
  logic [7:0] strobe_r;
  logic [7:0] hold_r;
  logic done_r;
  logic refused_r;
  logic pulse_r;
  logic ind_s1_r;
  logic ind_s2_r;
  logic ind_d_r;
  logic [7:0] wake_r;
  logic [31:0] rdout_nxt;
  logic word_mode;
  logic sample_d_r;
  logic stat_rd;
  logic [1:0] lane_en;
  logic [15:0] rd_lanes;

  pfc_seq_if sif ();

  pfc_seq u_seq (
    .clk_sys(clk_sys),
    .rst(rst),
    .sq(sif.seq)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign word_mode = ctrl_r[`PFC_CTRL_WORD_BIT];

  // Status read clears the sticky flags
  assign stat_rd = reg_rd && hit(reg_addr, `PFC_OFF_STATUS);

  // Byte lanes: low lane always used, high lane only in word mode
  generate
    for (genvar gl = 0; gl < 2; gl++) begin : g_lane
      assign lane_en[gl] = (gl == 0) || word_mode;
      assign rd_lanes[gl*8 +: 8] = lane_en[gl] ? flash_dq_i[gl*8 +: 8] : 8'h00;
    end
  endgenerate

  // Control: reset line, width select, program enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r <= `PFC_CTRL_RESET_VAL;
    end else if (reg_wr && hit(reg_addr, `PFC_OFF_CTRL)) begin
      ctrl_r <= reg_wdata[2:0];
    end
  end

  // Wake counter after releasing reset line
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_r <= 8'h00;
    end else if (!ctrl_r[`PFC_CTRL_RESET_BIT]) begin
      wake_r <= 8'(`PFC_CYC_WAKE);
    end else if (wake_r != 8'h00) begin
      wake_r <= wake_r - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_r <= '0;
      wdata_r <= 16'h0000;
    end else if (reg_wr && !sif.busy) begin
      if (hit(reg_addr, `PFC_OFF_ADDR)) begin
        addr_r <= reg_wdata[ADDR_MSB:0];
      end
      if (hit(reg_addr, `PFC_OFF_WDATA)) begin
        wdata_r <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      setup_r <= 8'(`PFC_CYC_SETUP);
      strobe_r <= 8'(`PFC_CYC_STROBE);
      hold_r <= 8'(`PFC_CYC_HOLD);
    end else if (reg_wr && hit(reg_addr, `PFC_OFF_TIMING)) begin
      setup_r <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
      strobe_r <= (reg_wdata[15:8] == 8'h00) ? 8'h01 : reg_wdata[15:8];
      hold_r <= (reg_wdata[23:16] == 8'h00) ? 8'h01 : reg_wdata[23:16];
    end
  end

  // Command launch; commands refused while reset low or waking
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sif.start <= 1'b0;
      sif.op <= PFC_OP_NONE;
      refused_r <= 1'b0;
    end else begin
      sif.start <= 1'b0;
      if (reg_wr && hit(reg_addr, `PFC_OFF_CMD) && !sif.busy && !sif.start) begin
        if (!ctrl_r[`PFC_CTRL_RESET_BIT] || wake_r != 8'h00) begin
          refused_r <= 1'b1;
        end else if (reg_wdata[1:0] == `PFC_CMD_READ) begin
          sif.start <= 1'b1;
          sif.op <= PFC_OP_READ;
        end else if (reg_wdata[1:0] == `PFC_CMD_WRITE) begin
          sif.start <= 1'b1;
          sif.op <= PFC_OP_WRITE;
        end
      end else if (stat_rd) begin
        refused_r <= 1'b0;
      end
    end
  end

  assign sif.setup_cyc = setup_r;
  assign sif.strobe_cyc = strobe_r;
  assign sif.hold_cyc = hold_r;

  // Select and strobe pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_ce <= CE_IDLE;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      flash_ce <= sif.drive_ce ? CE_ACTIVE : CE_IDLE;
      flash_oe_n <= !sif.drive_oe;
      flash_we_n <= !sif.drive_we;
    end
  end

  // Address pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_addr <= '0;
      byte_lane_select <= 1'b0;
    end else begin
      flash_addr <= addr_r[ADDR_MSB:1];
      byte_lane_select <= word_mode ? 1'b0 : addr_r[0];
    end
  end

  // Data pins; high lane only driven in word mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_dq_o <= 16'h0000;
      flash_dq_oe <= 2'h0;
    end else begin
      flash_dq_o <= wdata_r;
      flash_dq_oe <= lane_en & {2{sif.drive_data}};
    end
  end

  // Device mode pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_byte_n <= 1'b0;
      reset_powerdown_n <= 1'b0;
      program_enable_level <= 1'b0;
    end else begin
      flash_byte_n <= word_mode;
      reset_powerdown_n <= ctrl_r[`PFC_CTRL_RESET_BIT];
      program_enable_level <= ctrl_r[`PFC_CTRL_PEN_BIT];
    end
  end

  // Capture one edge after the last internal strobe cycle, while the
  // registered read enable still stands low on the pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sample_d_r <= 1'b0;
    end else begin
      sample_d_r <= sif.sample;
    end
  end

  // Read capture; high lane only meaningful in word mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (sample_d_r) begin
      rdata_r <= rd_lanes;
    end
  end

  // Indicator synchroniser and pulse catch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ind_s1_r <= 1'b1;
      ind_s2_r <= 1'b1;
      ind_d_r <= 1'b1;
    end else begin
      ind_s1_r <= state_machine_indicator;
      ind_s2_r <= ind_s1_r;
      ind_d_r <= ind_s2_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulse_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      // Set wins over read clear
      if (ind_d_r && !ind_s2_r) begin
        pulse_r <= 1'b1;
      end else if (stat_rd) begin
        pulse_r <= 1'b0;
      end
      if (sif.done) begin
        done_r <= 1'b1;
      end else if (stat_rd) begin
        done_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rdout_nxt = 32'h0000_0000;
    if (hit(reg_addr, `PFC_OFF_CTRL)) begin
      rdout_nxt = {29'h0, ctrl_r};
    end else if (hit(reg_addr, `PFC_OFF_ADDR)) begin
      rdout_nxt = 32'(addr_r);
    end else if (hit(reg_addr, `PFC_OFF_WDATA)) begin
      rdout_nxt = {16'h0000, wdata_r};
    end else if (hit(reg_addr, `PFC_OFF_STATUS)) begin
      rdout_nxt[`PFC_ST_BUSY_BIT] = sif.busy || sif.start;
      rdout_nxt[`PFC_ST_DONE_BIT] = done_r;
      rdout_nxt[`PFC_ST_READY_BIT] = ind_s2_r;
      rdout_nxt[`PFC_ST_PULSE_BIT] = pulse_r;
      rdout_nxt[`PFC_ST_REFUSED_BIT] = refused_r;
    end else if (hit(reg_addr, `PFC_OFF_RDATA)) begin
      rdout_nxt = {16'h0000, rdata_r};
    end else if (hit(reg_addr, `PFC_OFF_TIMING)) begin
      rdout_nxt = {8'h00, hold_r, strobe_r, setup_r};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdout_nxt;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule : pfc_ctrl

// ### design/pfc_pkg.sv
package pfc_pkg;
  typedef enum logic [1:0] {
    PFC_OP_NONE,
    PFC_OP_READ,
    PFC_OP_WRITE
  } pfc_op_t;
endpackage : pfc_pkg

// ### design/pfc_seq.sv
`timescale 1ns/1ps
module pfc_seq
  import pfc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control side
  pfc_seq_if.seq sq
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_DONE} pfc_sst_t;
  pfc_sst_t st_r;
  logic [7:0] cnt_r;
  pfc_op_t op_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= S_IDLE;
      cnt_r <= 8'h00;
      op_r <= PFC_OP_NONE;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          if (sq.start) begin
            op_r <= sq.op;
            cnt_r <= sq.setup_cyc;
            st_r <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_r <= 8'h01) begin
            cnt_r <= sq.strobe_cyc;
            st_r <= S_STROBE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_STROBE: begin
          if (cnt_r <= 8'h01) begin
            cnt_r <= sq.hold_cyc;
            st_r <= S_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_HOLD: begin
          if (cnt_r <= 8'h01) begin
            st_r <= S_DONE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_DONE: st_r <= S_IDLE;
      endcase
    end
  end

  // Chip select spans setup, strobe and hold
  assign sq.drive_ce = (st_r == S_SETUP) || (st_r == S_STROBE) || (st_r == S_HOLD);
  assign sq.drive_oe = (op_r == PFC_OP_READ) && (st_r == S_STROBE);
  assign sq.drive_we = (op_r == PFC_OP_WRITE) && (st_r == S_STROBE);
  // Data held through hold after strobe rises
  assign sq.drive_data = (op_r == PFC_OP_WRITE) && sq.drive_ce;
  assign sq.sample = (op_r == PFC_OP_READ) && (st_r == S_STROBE) && (cnt_r <= 8'h01);
  assign sq.busy = (st_r != S_IDLE);
  assign sq.done = (st_r == S_DONE);
endmodule : pfc_seq

// ### design/pfc_seq_if.sv
`timescale 1ns/1ps
interface pfc_seq_if;
  import pfc_pkg::*;
  logic start;
  pfc_op_t op;
  logic [7:0] setup_cyc;
  logic [7:0] strobe_cyc;
  logic [7:0] hold_cyc;
  logic drive_ce;
  logic drive_oe;
  logic drive_we;
  logic drive_data;
  logic sample;
  logic busy;
  logic done;
  modport ctl (output start, op, setup_cyc, strobe_cyc, hold_cyc,
    input drive_ce, drive_oe, drive_we, drive_data, sample, busy, done);
  modport seq (input start, op, setup_cyc, strobe_cyc, hold_cyc,
    output drive_ce, drive_oe, drive_we, drive_data, sample, busy, done);
endinterface : pfc_seq_if

// ### testbench/pfc_flash_model.sv
`timescale 1ns/1ps
module pfc_flash_model #(
  parameter int ADDR_MSB = 23
) (
  // Address and control
  input wire logic [ADDR_MSB:1] addr,
  input wire logic lane,
  input wire logic [2:0] ce,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic byte_n,
  input wire logic pd_n,
  input wire logic pen,
  // Data and indicator
  input wire logic [15:0] dq_o,
  input wire logic [1:0] dq_oe,
  output logic [15:0] dq_i,
  output logic indicator
);
  logic [15:0] mem [0:15];
  logic [15:0] held = 16'h0000;
  logic [15:0] v;
  logic [15:0] m;
  logic busy_n = 1'b1;
  logic sel;
  logic [3:0] idx;
  assign sel = (ce == 3'h0) && pd_n;
  assign idx = {addr[ADDR_MSB], addr[3:1]};
  assign indicator = busy_n | ~pd_n;
  // Floating lanes show the inverse of what was last on them
  always @* begin
    v = mem[idx];
    m = 16'h0000;
    if (!byte_n && lane) v[7:0] = v[15:8];
    if (sel && !oe_n) m = byte_n ? 16'hFFFF : 16'h00FF;
    if (dq_oe[0]) {v[7:0], m[7:0]} = {dq_o[7:0], 8'hFF};
    if (dq_oe[1]) {v[15:8], m[15:8]} = {dq_o[15:8], 8'hFF};
    held = (held & ~m) | (v & m);
    dq_i = (v & m) | (~held & ~m);
  end
  always @(posedge we_n) begin
    if (sel && pen) begin
      if (byte_n) mem[idx] <= dq_o;
      else if (lane) mem[idx][15:8] <= dq_o[7:0];
      else mem[idx][7:0] <= dq_o[7:0];
      busy_n = 1'b0;
      busy_n <= #100 1'b1;
    end
  end
  // Reset during a program aborts it and leaves the word unreliable
  always @(negedge pd_n) begin
    if (!busy_n) begin
      busy_n = 1'b1;
      mem[idx] = ~mem[idx];
    end
  end
endmodule : pfc_flash_model

// ### testbench/pfc_sva.sv
`timescale 1ns/1ps
module pfc_sva #(
  parameter int ADDR_MSB = 23
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Flash pins
  input wire logic [ADDR_MSB:1] flash_addr,
  input wire logic [2:0] flash_ce,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_byte_n,
  input wire logic reset_powerdown_n,
  input wire logic [1:0] flash_dq_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_we_in_select: assert property (!flash_we_n |-> flash_ce == 3'h0)
    else $error("write strobe outside select");
  a_strobes_apart: assert property (flash_we_n || flash_oe_n)
    else $error("both strobes low");
  a_we_rise_held: assert property ($rose(flash_we_n) |-> flash_dq_oe[0] && $stable(flash_addr))
    else $error("data or address moved at strobe rise");
  a_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
    else $error("write strobe width wrong");
  a_read_no_drive: assert property (!flash_oe_n |-> flash_dq_oe == 2'h0)
    else $error("host drives bus in read");
  a_dq_in_select: assert property (|flash_dq_oe |-> flash_ce == 3'h0)
    else $error("bus driven while idle");
  a_byte_hi_free: assert property (!flash_byte_n |-> !flash_dq_oe[1])
    else $error("high lane driven in byte mode");
  a_reset_quiet: assert property (!reset_powerdown_n |-> flash_we_n && flash_ce == 3'h7)
    else $error("access while device in reset");
endmodule : pfc_sva

bind pfc_ctrl pfc_sva #(.ADDR_MSB(ADDR_MSB)) chk_u (.clk_sys, .rst, .flash_addr, .flash_ce,
  .flash_oe_n, .flash_we_n, .flash_byte_n, .reset_powerdown_n, .flash_dq_oe);

// ### testbench/testbench.sv
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, v;
  logic [23:1] addr;
  logic lane, oe_n, we_n, byte_n, pd_n, pen, indicator;
  logic [31:0] tim_def;
  logic [2:0] ce;
  logic [15:0] dq_o, dq_i;
  logic [1:0] dq_oe;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;
  assign tim_def = {8'h00, 8'(`PFC_CYC_HOLD), 8'(`PFC_CYC_STROBE), 8'(`PFC_CYC_SETUP)};
  pfc_ctrl dut_u (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .flash_addr(addr), .byte_lane_select(lane), .flash_ce(ce), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_byte_n(byte_n), .reset_powerdown_n(pd_n),
    .program_enable_level(pen), .flash_dq_i(dq_i), .flash_dq_o(dq_o),
    .flash_dq_oe(dq_oe), .state_machine_indicator(indicator));
  pfc_flash_model dev_u (.addr, .lane, .ce, .oe_n, .we_n, .byte_n, .pd_n, .pen,
    .dq_o, .dq_oe, .dq_i, .indicator);
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // Start a command, let it finish, then compare the status flags
  task automatic go(input logic [1:0] c, input logic [4:0] st);
    wr(`PFC_OFF_CMD, {30'h0, c});
    repeat (20) @(posedge clk_sys);
    rd(`PFC_OFF_STATUS);
    chk({27'h0, v[4:0]}, {27'h0, st});
  endtask : go
  task automatic put(input logic [31:0] a, input logic [31:0] d, input logic [4:0] st);
    wr(`PFC_OFF_ADDR, a);
    wr(`PFC_OFF_WDATA, d);
    go(`PFC_CMD_WRITE, st);
  endtask : put
  task automatic get(input logic [31:0] a, input logic [31:0] exp);
    wr(`PFC_OFF_ADDR, a);
    go(`PFC_CMD_READ, 5'h06);
    rd(`PFC_OFF_RDATA);
    chk(v, exp);
  endtask : get
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`PFC_OFF_CTRL);
    chk(v, 32'h0);
    go(`PFC_CMD_WRITE, 5'h14);
    rd(`PFC_OFF_TIMING);
    chk(v, tim_def);
    wr(`PFC_OFF_TIMING, 32'h0);
    rd(`PFC_OFF_TIMING);
    chk(v, 32'h0001_0101);
    wr(`PFC_OFF_TIMING, tim_def);
    $display("test reset done");
    wr(`PFC_OFF_CTRL, 32'h7);
    repeat (12) @(posedge clk_sys);
    put(32'h10, 32'hA5C3, 5'h0E);
    put(32'h80_0010, 32'h1234, 5'h0E);
    get(32'h10, 32'hA5C3);
    get(32'h80_0010, 32'h1234);
    wr(`PFC_OFF_CMD, {30'h0, `PFC_CMD_READ});
    rd(`PFC_OFF_STATUS);
    chk({31'h0, v[`PFC_ST_BUSY_BIT]}, 32'h1);
    repeat (20) @(posedge clk_sys);
    $display("test word done");
    wr(`PFC_OFF_CTRL, 32'h5);
    put(32'h11, 32'h5A, 5'h0E);
    get(32'h11, 32'h5A);
    get(32'h10, 32'hC3);
    $display("test byte done");
    wr(`PFC_OFF_CTRL, 32'h3);
    put(32'h10, 32'h7777, 5'h06);
    get(32'h10, 32'h5AC3);
    wr(`PFC_OFF_CTRL, 32'h2);
    put(32'h10, 32'h1111, 5'h14);
    wr(`PFC_OFF_CTRL, 32'h7);
    repeat (12) @(posedge clk_sys);
    get(32'h10, 32'h5AC3);
    $display("test protect done");
    conclude();
  end
endmodule : testbench
